// File: logic/cms_pkg.sv
// Constants and types for the cell monitor converter sequencer
`default_nettype none

package cms_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 8;
   localparam int SLOT_NS = 8000;
   localparam int SLOT_CYC = SLOT_NS / CLK_NS;
   localparam int SLOTS = 24;
   localparam int BURST_ROUNDS = 8;
   localparam int DLY_UNIT_NS = 1000;
   localparam int DLY_UNIT_CYC = DLY_UNIT_NS / CLK_NS;
   localparam int FILT_SHIFT = 3;

   // ****************************************
   // Register offsets and fields
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h01;
   localparam logic [7:0] ADDR_CELLS = 8'h02;
   localparam logic [7:0] ADDR_GPIO = 8'h03;
   localparam logic [7:0] ADDR_AUXSEL = 8'h04;
   localparam logic [7:0] ADDR_CAL = 8'h05;
   localparam logic [7:0] ADDR_STAT = 8'h06;
   localparam logic [7:0] ADDR_CMD = 8'h07;
   localparam logic [7:0] ADDR_RES = 8'h40;
   localparam int RES_WORDS = 48;
   localparam int CTRL_GO = 0;
   localparam int CTRL_MODE = 1;
   localparam int CTRL_CFLT = 3;
   localparam int CTRL_SFLT = 4;
   localparam int CTRL_AUX = 5;
   localparam int ST_FFAIL = 2;
   localparam int CMD_RST = 0;
   localparam logic [3:0] CELLS_RST = 4'hF;
   localparam logic [15:0] RES_DEFAULT = 16'h8000;

   // ****************************************
   // Run modes, slots and result words
   // ****************************************
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_BURST = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h2;
   localparam logic [4:0] S_DIE1 = 5'h00;
   localparam logic [4:0] S_THERMISTOR_REFERENCE = 5'h01;
   localparam logic [4:0] S_CELL0 = 5'h02;
   localparam logic [4:0] S_CURR = 5'h12;
   localparam logic [4:0] S_GPIO = 5'h13;
   localparam logic [4:0] A_DIE2 = 5'h00;
   localparam logic [4:0] A_CELL = 5'h01;
   localparam logic [4:0] A_MISC0 = 5'h02;
   localparam logic [4:0] A_GPIO = 5'h0E;
   localparam logic [4:0] AUXSEL_CB0 = 5'h02;
   localparam logic [5:0] W_DIE1 = 6'h00;
   localparam logic [5:0] W_THERMISTOR_REFERENCE = 6'h01;
   localparam logic [5:0] W_CELL0 = 6'h02;
   localparam logic [5:0] W_CURR = 6'h12;
   localparam logic [5:0] W_GPIO0 = 6'h13;
   localparam logic [5:0] W_DIE2 = 6'h20;
   localparam logic [5:0] W_AUXCELL = 6'h21;
   localparam logic [5:0] W_MISC0 = 6'h22;

   // ****************************************
   // Die temperature scale
   // ****************************************
   localparam int TEMP_CODE_PER_DEG = 100;
   localparam logic signed [15:0] TEMP_MAX_CODE =
      16'(200 * TEMP_CODE_PER_DEG);
   localparam logic signed [15:0] TEMP_MIN_CODE =
      16'(-100 * TEMP_CODE_PER_DEG);

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN = 3'b100
   } cms_main_e;

   typedef struct packed {
      logic [1:0] mode;
      logic cflt;
      logic sflt;
      logic [5:0] dly;
      logic [3:0] cells;
      logic [7:0] gpio_en;
      logic [7:0] cal;
      logic [4:0] aux_sel;
   } cms_cfg_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cms_bus_s;

   typedef struct packed {
      logic [4:0] slot;
      logic conv;
      logic [2:0] gpio;
   } cms_conv_s;

endpackage : cms_pkg

`default_nettype wire

// File: logic/cms_slot_timer.sv
// Round robin slot timer, one instance for each converter
`default_nettype none

module cms_slot_timer (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic restart_i,
   input wire logic run_i,
   output logic [4:0] slot_o,
   output logic [2:0] round_o,
   output logic slot_end_o,
   output logic round_end_o
);

   typedef struct packed {
      logic [9:0] cyc;
      logic [4:0] slot;
      logic [2:0] round;
   } cms_tmr_s;

   cms_tmr_s q;
   cms_tmr_s n;

   // Count cycles per slot, slots per round; hold while not running
   always_comb begin
      n = q;
      slot_end_o = 1'b0;
      round_end_o = 1'b0;
      if (restart_i) begin
         n = '0;
      end else if (run_i) begin
         n.cyc = q.cyc + 10'h001;
         if (q.cyc == 10'(cms_pkg::SLOT_CYC - 1)) begin
            n.cyc = '0;
            n.slot = q.slot + 5'h01;
            slot_end_o = 1'b1;
            if (q.slot == 5'(cms_pkg::SLOTS - 1)) begin
               n.slot = '0;
               n.round = q.round + 3'h1;
               round_end_o = 1'b1;
            end
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign slot_o = q.slot;
   assign round_o = q.round;

endmodule : cms_slot_timer

`default_nettype wire

// File: logic/cms_temp_clamp.sv
// Die temperature clamp to the reported range
`default_nettype none

module cms_temp_clamp (
   input wire logic [15:0] raw_i,
   output logic [15:0] temp_o
);

   // Two's complement, zero code is zero degrees
   always_comb begin
      if ($signed(raw_i) > cms_pkg::TEMP_MAX_CODE) begin
         temp_o = cms_pkg::TEMP_MAX_CODE;
      end else if ($signed(raw_i) < cms_pkg::TEMP_MIN_CODE) begin
         temp_o = cms_pkg::TEMP_MIN_CODE;
      end else begin
         temp_o = raw_i;
      end
   end

endmodule : cms_temp_clamp

`default_nettype wire

// File: logic/cms_sequencer.sv
// Main and auxiliary converter sequencer with result registers
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none

module cms_sequencer (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire cms_pkg::cms_bus_s bus_i,
   output logic [7:0] rdata_o,
   input wire logic active_mode_i,
   input wire logic [15:0] main_result_i,
   input wire logic [15:0] aux_result_i,
   output cms_pkg::cms_conv_s main_conv_o,
   output cms_pkg::cms_conv_s aux_conv_o,
   output logic cs_run_o,
   output logic [15:0] level_shift_en_o
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      cms_pkg::cms_main_e st;
      logic [12:0] dly;
      cms_pkg::cms_cfg_s sw;
      cms_pkg::cms_cfg_s cfg;
      logic [4:0] aux_sel;
      logic aux_en;
      logic drdy;
      logic ffail;
      logic reinit;
      logic act1;
      logic act2;
      logic [15:0] lvl;
      logic [7:0] rdata;
      logic [47:0] hold;
      logic [47:0] first;
      logic [47:0][15:0] res;
   } cms_st_s;

   cms_st_s q;
   cms_st_s n;
   logic go;
   logic aux_rise;
   logic m_run;
   logic a_run;
   logic [4:0] m_slot;
   logic [4:0] a_slot;
   logic [2:0] m_round;
   logic [2:0] a_round;
   logic m_end;
   logic m_rend;
   logic a_end;
   logic [15:0] die1;
   logic [15:0] die2;

   // ****************************************
   // Functions
   // ****************************************
   // Main slot measured or skipped
   function automatic logic main_on(input logic [4:0] s,
         input logic [2:0] r, input cms_pkg::cms_cfg_s c);
      logic on;
      on = 1'b0;
      if (s == cms_pkg::S_DIE1 || s == cms_pkg::S_THERMISTOR_REFERENCE ||
            s == cms_pkg::S_CURR) begin
         on = 1'b1;
      end else if (s >= cms_pkg::S_CELL0 && s < cms_pkg::S_CURR) begin
         on = 4'(s - cms_pkg::S_CELL0) <= c.cells;
      end else if (s == cms_pkg::S_GPIO) begin
         on = c.gpio_en[r];
      end
      return on;
   endfunction : main_on

   // Auxiliary cell lock on a single active channel
   function automatic logic aux_lock(input logic [4:0] sel,
         input logic [3:0] cells);
      logic [4:0] cb;
      cb = sel - cms_pkg::AUXSEL_CB0;
      return sel >= cms_pkg::AUXSEL_CB0 && cb <= {1'b0, cells};
   endfunction : aux_lock

   // Auxiliary slot measured or skipped
   function automatic logic aux_on(input logic [4:0] s,
         input logic [4:0] sel, input logic [3:0] cells);
      logic on;
      on = s <= cms_pkg::A_GPIO;
      if (s == cms_pkg::A_CELL) begin
         on = aux_lock(sel, cells);
      end
      return on;
   endfunction : aux_on

   // New word with low byte frozen while held
   function automatic logic [15:0] merge(input logic [15:0] old,
         input logic [15:0] val, input logic hold);
      return {val[15:8], hold ? old[7:0] : val[7:0]};
   endfunction : merge

   // ****************************************
   // Slot timers and temperature clamps
   // ****************************************
   assign m_run = q.st == cms_pkg::ST_RUN && q.act2;
   assign a_run = q.aux_en && q.act2;

   cms_slot_timer u_main_tmr (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .restart_i(go),
      .run_i(m_run),
      .slot_o(m_slot),
      .round_o(m_round),
      .slot_end_o(m_end),
      .round_end_o(m_rend)
   );

   cms_slot_timer u_aux_tmr (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .restart_i(aux_rise),
      .run_i(a_run),
      .slot_o(a_slot),
      .round_o(a_round),
      .slot_end_o(a_end),
      .round_end_o()
   );

   cms_temp_clamp u_die1 (
      .raw_i(main_result_i),
      .temp_o(die1)
   );

   cms_temp_clamp u_die2 (
      .raw_i(aux_result_i),
      .temp_o(die2)
   );

   // ****************************************
   // Next state
   // ****************************************
   assign go = bus_i.wr && bus_i.addr == cms_pkg::ADDR_CTRL &&
      bus_i.wdata[cms_pkg::CTRL_GO];
   assign aux_rise = bus_i.wr && bus_i.addr == cms_pkg::ADDR_CTRL &&
      bus_i.wdata[cms_pkg::CTRL_AUX] && !q.aux_en;

   always_comb begin
      logic [5:0] mw;
      logic mv;
      logic mf;
      logic [15:0] mval;
      logic signed [16:0] diff;
      logic [5:0] aw;
      logic av;
      logic [5:0] rw;
      mw = '0;
      mv = 1'b0;
      mf = 1'b0;
      mval = main_result_i;
      diff = '0;
      aw = '0;
      av = 1'b0;
      rw = '0;
      n = q;
      n.act1 = active_mode_i;
      n.act2 = q.act1;
      n.rdata = '0;
      n.lvl = q.act2 ? 16'((17'h00002 << q.sw.cells) - 17'h00001) :
         16'h0000;

      // Software writes to the shadow settings, the auxiliary enable, the fault flag clear and the reset command
      if (bus_i.wr) begin
         case (bus_i.addr)
            cms_pkg::ADDR_CTRL: begin
               n.sw.mode = bus_i.wdata[cms_pkg::CTRL_MODE +: 2];
               n.sw.cflt = bus_i.wdata[cms_pkg::CTRL_CFLT];
               n.sw.sflt = bus_i.wdata[cms_pkg::CTRL_SFLT];
               n.aux_en = bus_i.wdata[cms_pkg::CTRL_AUX];
            end
            cms_pkg::ADDR_DELAY: n.sw.dly = bus_i.wdata[5:0];
            cms_pkg::ADDR_CELLS: n.sw.cells = bus_i.wdata[3:0];
            cms_pkg::ADDR_GPIO: n.sw.gpio_en = bus_i.wdata;
            cms_pkg::ADDR_AUXSEL: n.sw.aux_sel = bus_i.wdata[4:0];
            cms_pkg::ADDR_CAL: n.sw.cal = bus_i.wdata;
            cms_pkg::ADDR_STAT: begin
               if (bus_i.wdata[cms_pkg::ST_FFAIL]) begin
                  n.ffail = 1'b0;
               end
            end
            cms_pkg::ADDR_CMD: begin
               if (bus_i.wdata[cms_pkg::CMD_RST]) begin
                  n.st = cms_pkg::ST_IDLE;
                  n.reinit = q.cfg.cflt;
               end
            end
            default: ;
         endcase
      end

      // Auxiliary enable clears its results
      if (aux_rise) begin
         n.aux_sel = n.sw.aux_sel;
         for (int k = 32; k < cms_pkg::RES_WORDS; k++) begin
            n.res[k] = cms_pkg::RES_DEFAULT;
            n.hold[k] = 1'b0;
         end
      end

      // Go latches settings and starts or stops
      if (go) begin
         n.cfg = n.sw;
         if (n.sw.cflt && q.reinit) begin
            n.ffail = 1'b1;
         end
         if (!n.sw.cflt) begin
            n.reinit = 1'b0;
         end
         if (n.sw.mode == cms_pkg::MODE_BURST ||
               n.sw.mode == cms_pkg::MODE_CONT) begin
            n.st = cms_pkg::ST_DELAY;
            n.dly = 13'(n.sw.dly * cms_pkg::DLY_UNIT_CYC);
            n.drdy = 1'b0;
            n.first = '1;
            for (int k = 0; k < 32; k++) begin
               n.res[k] = cms_pkg::RES_DEFAULT;
               n.hold[k] = 1'b0;
            end
         end else begin
            n.st = cms_pkg::ST_IDLE;
         end
      end

      // Main sequence, frozen outside active mode
      unique case (q.st)
         cms_pkg::ST_IDLE: ;
         cms_pkg::ST_DELAY: begin
            if (!go && q.act2) begin
               if (q.dly == 13'h0000) begin
                  n.st = cms_pkg::ST_RUN;
               end else begin
                  n.dly = q.dly - 13'h0001;
               end
            end
         end
         cms_pkg::ST_RUN: begin
            if (m_rend && m_round == 3'(cms_pkg::BURST_ROUNDS - 1)) begin
               n.drdy = 1'b1;
               if (q.cfg.mode == cms_pkg::MODE_BURST && !go) begin
                  n.st = cms_pkg::ST_IDLE;
               end
            end
         end
         default: n.st = cms_pkg::ST_IDLE;
      endcase

      // Main slot result selection
      if (m_end && !go && main_on(m_slot, m_round, q.cfg)) begin
         mv = 1'b1;
         if (m_slot == cms_pkg::S_DIE1) begin
            mw = cms_pkg::W_DIE1;
            mval = die1;
         end else if (m_slot == cms_pkg::S_THERMISTOR_REFERENCE) begin
            mw = cms_pkg::W_THERMISTOR_REFERENCE;
         end else if (m_slot == cms_pkg::S_CURR) begin
            mw = cms_pkg::W_CURR;
            mf = q.cfg.sflt;
         end else if (m_slot == cms_pkg::S_GPIO) begin
            mw = cms_pkg::W_GPIO0 + {3'h0, m_round};
         end else begin
            mw = 6'(m_slot - cms_pkg::S_CELL0) + cms_pkg::W_CELL0;
            mval = main_result_i + {{8{q.cfg.cal[7]}}, q.cfg.cal};
            mf = q.cfg.cflt;
         end
      end

      // Single pole filter, first sample taken as is
      if (mv) begin
         if (mf && !q.first[mw]) begin
            diff = $signed({mval[15], mval}) -
               $signed({q.res[mw][15], q.res[mw]});
            mval = q.res[mw] + 16'(diff >>> cms_pkg::FILT_SHIFT);
         end
         n.first[mw] = 1'b0;
         n.res[mw] = merge(q.res[mw], mval, q.hold[mw]);
      end

      // Auxiliary slot results
      if (a_end && !aux_rise && aux_on(a_slot, q.aux_sel, q.cfg.cells) &&
            a_slot != cms_pkg::A_GPIO) begin
         av = 1'b1;
         if (a_slot == cms_pkg::A_DIE2) begin
            aw = cms_pkg::W_DIE2;
         end else if (a_slot == cms_pkg::A_CELL) begin
            aw = cms_pkg::W_AUXCELL;
         end else begin
            aw = 6'(a_slot - cms_pkg::A_MISC0) + cms_pkg::W_MISC0;
         end
      end
      if (av) begin
         n.res[aw] = merge(q.res[aw],
            a_slot == cms_pkg::A_DIE2 ? die2 : aux_result_i,
            q.hold[aw]);
      end

      // Register reads, data in the next cycle
      if (bus_i.rd) begin
         case (bus_i.addr)
            cms_pkg::ADDR_CTRL: n.rdata = {2'h0, q.aux_en, q.sw.sflt,
               q.sw.cflt, q.sw.mode, 1'b0};
            cms_pkg::ADDR_DELAY: n.rdata = {2'h0, q.sw.dly};
            cms_pkg::ADDR_CELLS: n.rdata = {4'h0, q.sw.cells};
            cms_pkg::ADDR_GPIO: n.rdata = q.sw.gpio_en;
            cms_pkg::ADDR_AUXSEL: n.rdata = {3'h0, q.sw.aux_sel};
            cms_pkg::ADDR_CAL: n.rdata = q.sw.cal;
            cms_pkg::ADDR_STAT: n.rdata = {3'h0, a_run,
               q.st != cms_pkg::ST_IDLE && !q.act2, q.ffail, q.drdy,
               q.st != cms_pkg::ST_IDLE};
            default: begin
               if (bus_i.addr >= cms_pkg::ADDR_RES && bus_i.addr <
                     8'(cms_pkg::ADDR_RES + 2 * cms_pkg::RES_WORDS)) begin
                  rw = 6'((bus_i.addr - cms_pkg::ADDR_RES) >> 1);
                  if (!bus_i.addr[0]) begin
                     n.rdata = q.res[rw][15:8];
                     n.hold[rw] = 1'b1;
                  end else begin
                     n.rdata = q.res[rw][7:0];
                     n.hold[rw] = 1'b0;
                  end
               end
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.st <= cms_pkg::ST_IDLE;
         q.sw.cells <= cms_pkg::CELLS_RST;
         q.cfg.cells <= cms_pkg::CELLS_RST;
         q.first <= '1;
         q.res <= {cms_pkg::RES_WORDS{cms_pkg::RES_DEFAULT}};
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata_o = q.rdata;
   assign level_shift_en_o = q.lvl;
   assign cs_run_o = m_run;
   assign main_conv_o = '{slot: m_slot, gpio: m_round,
      conv: m_run && main_on(m_slot, m_round, q.cfg)};
   assign aux_conv_o = '{slot: a_slot, gpio: a_round,
      conv: a_run && aux_on(a_slot, q.aux_sel, q.cfg.cells)};

endmodule : cms_sequencer

`default_nettype wire

// File: tb/cms_seq_asserts.sv
// Port checker for the converter sequencer
`default_nettype none

module cms_seq_asserts (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire cms_pkg::cms_bus_s bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic active_mode_i,
   input wire cms_pkg::cms_conv_s main_conv_o,
   input wire cms_pkg::cms_conv_s aux_conv_o,
   input wire logic cs_run_o,
   input wire logic [15:0] level_shift_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // ****************************************
   // Sequences
   // ****************************************
   // Device held asleep long enough to pass the synchroniser
   sequence asleep_s;
      !active_mode_i [*5];
   endsequence
   // Go command carrying the stop mode
   sequence stop_go_s;
      bus_i.wr && bus_i.addr == cms_pkg::ADDR_CTRL && bus_i.wdata[0]
         && bus_i.wdata[2:1] == cms_pkg::MODE_STOP;
   endsequence

   // ****************************************
   // Assertions
   // ****************************************
   rdata_idle_a:
   assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data outside a read answer");
   unmapped_read_a:
   assert property (bus_i.rd && bus_i.addr inside {[8'h08:8'h3F]}
      |=> rdata_o == 8'h00) else $error("unmapped read not zero");
   slot_range_a:
   assert property (main_conv_o.slot < 5'd24 && aux_conv_o.slot < 5'd24)
      else $error("slot index beyond 23");
   slot_step_a:
   assert property ($changed(main_conv_o.slot) |-> main_conv_o.slot ==
      5'($past(main_conv_o.slot) + 5'd1) || main_conv_o.slot == 5'h00)
      else $error("slot skipped");
   gpio_round_a:
   assert property ($changed(main_conv_o.gpio) |-> main_conv_o.slot == 5'h00)
      else $error("gpio index moved inside a round");
   sleep_quiet_a:
   assert property (asleep_s |-> !main_conv_o.conv && !cs_run_o
      && level_shift_en_o == 16'h0000) else $error("activity in sleep");
   sleep_hold_a:
   assert property (asleep_s |=> $stable(main_conv_o.slot)
      && $stable(main_conv_o.gpio)) else $error("state moved in sleep");
   stop_go_a:
   assert property (stop_go_s |=> ##2 (!cs_run_o && !main_conv_o.conv))
      else $error("converter still runs after stop");
   shift_mask_a:
   assert property ((level_shift_en_o & (level_shift_en_o + 16'h0001))
      == 16'h0000) else $error("level shift mask not contiguous");
endmodule : cms_seq_asserts

`default_nettype wire

// File: tb/cms_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module cms_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i;
   logic rst_n_i;
   cms_pkg::cms_bus_s bus_i;
   logic [7:0] rdata_o;
   logic active_mode_i;
   logic [15:0] main_result_i;
   logic [15:0] aux_result_i;
   cms_pkg::cms_conv_s main_conv_o;
   cms_pkg::cms_conv_s aux_conv_o;
   logic cs_run_o;
   logic [15:0] level_shift_en_o;
   int mismatches;
   int comparisons;
   logic [7:0] rv;
   logic [4:0] sv;
   int n;

   cms_sequencer cms_sequencer_inst (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .bus_i(bus_i),
      .rdata_o(rdata_o),
      .active_mode_i(active_mode_i),
      .main_result_i(main_result_i),
      .aux_result_i(aux_result_i),
      .main_conv_o(main_conv_o),
      .aux_conv_o(aux_conv_o),
      .cs_run_o(cs_run_o),
      .level_shift_en_o(level_shift_en_o)
   );

   // ****************************************
   // Clock and converter samples
   // ****************************************
   // 125 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // Samples tagged with slot and round; die slot hits both clamps
   always @(posedge clk_sys_i) begin
      if (main_conv_o.slot == cms_pkg::S_DIE1)
         main_result_i <= (main_conv_o.gpio == 3'h0) ? 16'h7FFF : 16'h8000;
      else
         main_result_i <= {3'h0, main_conv_o.slot, 5'h00, main_conv_o.gpio};
      if (aux_conv_o.slot == cms_pkg::A_DIE2)
         aux_result_i <= 16'h8000;
      else
         aux_result_i <= {3'h7, aux_conv_o.slot, 5'h00, aux_conv_o.gpio};
   end

   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      bus_i.addr <= a;
      bus_i.wdata <= d;
      bus_i.wr <= 1'b1;
      @(posedge clk_sys_i);
      bus_i.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      bus_i.addr <= a;
      bus_i.rd <= 1'b1;
      @(posedge clk_sys_i);
      bus_i.rd <= 1'b0;
      @(negedge clk_sys_i);
      d = rdata_o;
   endtask : rd
   // High byte then low byte of one result word
   task automatic chk_word(input int k, input logic [15:0] e);
      logic [7:0] hi;
      logic [7:0] lo;
      rd(8'(cms_pkg::ADDR_RES + 2 * k), hi);
      rd(8'(cms_pkg::ADDR_RES + 2 * k + 1), lo);
      `CHK({hi, lo}, e)
   endtask : chk_word
   // Bounded wait for a slot index
   task automatic wait_slot(input logic [4:0] s);
      int i;
      for (i = 0; i < 30000 && main_conv_o.slot !== s; i++)
         @(negedge clk_sys_i);
      `CHK(main_conv_o.slot, s)
   endtask : wait_slot
   // Verdict and end of run
   task automatic test_done();
      if (mismatches == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // ****************************************
   // Tests
   // ****************************************
   // Hang guard
   initial begin
      repeat (90000) @(posedge clk_sys_i);
      mismatches++;
      test_done();
   end
   // Main sequence
   initial begin
      mismatches = 0;
      comparisons = 0;
      rst_n_i = 1'b0;
      bus_i = '0;
      active_mode_i = 1'b1;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      chk_word(0, cms_pkg::RES_DEFAULT);
      rd(8'h30, rv);
      `CHK(rv, 8'h00)
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[0], 1'b0)
      wr(cms_pkg::ADDR_DELAY, 8'h01);
      wr(cms_pkg::ADDR_CELLS, 8'h01);
      wr(cms_pkg::ADDR_GPIO, 8'h01);
      wr(cms_pkg::ADDR_CAL, 8'h00);
      wr(cms_pkg::ADDR_CTRL, 8'h03);
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[0], 1'b1)
      `CHK(rv[1], 1'b0)
      wr(cms_pkg::ADDR_CTRL, 8'h05);
      for (n = 0; n < 400 && main_conv_o.conv !== 1'b1; n++)
         @(negedge clk_sys_i);
      `CHK(n >= 120 && n <= 130, 1'b1)
      `CHK(cs_run_o, 1'b1)
      `CHK(level_shift_en_o, 16'h0003)
      wait_slot(5'd3);
      chk_word(0, 16'h4E20);
      rd(8'h44, rv);
      `CHK(rv, 8'h02)
      wait_slot(5'd5);
      chk_word(4, cms_pkg::RES_DEFAULT);
      wait_slot(5'd20);
      chk_word(19, 16'h1300);
      wait_slot(5'd1);
      chk_word(0, 16'hD8F0);
      wait_slot(5'd3);
      rd(8'h45, rv);
      `CHK(rv, 8'h00)
      chk_word(2, 16'h0200);
      wait_slot(5'd19);
      `CHK(main_conv_o.conv, 1'b0)
      `CHK(main_conv_o.gpio, 3'h1)
      wait_slot(5'd20);
      chk_word(20, cms_pkg::RES_DEFAULT);
      // Sleep in mid-round, then resume
      @(posedge clk_sys_i);
      active_mode_i <= 1'b0;
      repeat (10) @(negedge clk_sys_i);
      sv = main_conv_o.slot;
      `CHK(level_shift_en_o, 16'h0000)
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[3], 1'b1)
      repeat (1500) @(negedge clk_sys_i);
      `CHK(main_conv_o.slot, sv)
      @(posedge clk_sys_i);
      active_mode_i <= 1'b1;
      wait_slot(5'(sv + 5'd1));
      `CHK(level_shift_en_o, 16'h0003)
      // Stop from continuous mode
      wr(cms_pkg::ADDR_CTRL, 8'h01);
      repeat (3) @(negedge clk_sys_i);
      `CHK(cs_run_o, 1'b0)
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[0], 1'b0)
      // Converter reset with cell filter latched, go without re-arm
      wr(cms_pkg::ADDR_CTRL, 8'h09);
      wr(cms_pkg::ADDR_CMD, 8'h01);
      wr(cms_pkg::ADDR_CTRL, 8'h09);
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[2], 1'b1)
      // Clear the flag, then follow the re-arm procedure
      wr(cms_pkg::ADDR_STAT, 8'h04);
      wr(cms_pkg::ADDR_CMD, 8'h01);
      wr(cms_pkg::ADDR_CTRL, 8'h01);
      wr(cms_pkg::ADDR_CTRL, 8'h09);
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[2], 1'b0)
      // Auxiliary converter on current sense, cell word stays default
      wr(cms_pkg::ADDR_AUXSEL, 8'h01);
      wr(cms_pkg::ADDR_CTRL, 8'h20);
      for (n = 0; n < 4000 && aux_conv_o.slot !== 5'd3; n++)
         @(negedge clk_sys_i);
      `CHK(aux_conv_o.slot, 5'd3)
      chk_word(32, 16'hD8F0);
      chk_word(33, cms_pkg::RES_DEFAULT);
      chk_word(34, 16'hE200);
      rd(cms_pkg::ADDR_STAT, rv);
      `CHK(rv[4], 1'b1)
      // Re-enabling clears the auxiliary words
      wr(cms_pkg::ADDR_CTRL, 8'h00);
      wr(cms_pkg::ADDR_CTRL, 8'h20);
      chk_word(34, cms_pkg::RES_DEFAULT);
      test_done();
   end
endmodule : cms_sequencer_tb

bind cms_sequencer cms_seq_asserts cms_seq_asserts_inst (
   .clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i),
   .bus_i(bus_i),
   .rdata_o(rdata_o),
   .active_mode_i(active_mode_i),
   .main_conv_o(main_conv_o),
   .aux_conv_o(aux_conv_o),
   .cs_run_o(cs_run_o),
   .level_shift_en_o(level_shift_en_o)
);

`default_nettype wire
